// *** cior_top.v ***
// Card IO routing matrix: selector, isolation, static drive, pin levels and interrupt
`timescale 1ns/1ps
`include "cior_defs.vh"

module cior_top
(
	input  wire       i_clk_sys,
	input  wire       i_sys_rst,
	input  wire       i_reg_wr,
	input  wire [1:0] i_reg_addr,
	input  wire [7:0] i_reg_wdata,
	output wire [7:0] o_reg_rdata,
	input  wire       i_host_line_one,
	input  wire       i_host_line_two,
	input  wire       i_host_aux_one,
	input  wire       i_host_aux_two,
	output wire       o_host_line_one_rx,
	output wire       o_host_line_two_rx,
	output wire       o_host_aux_one_rx,
	output wire       o_host_aux_two_rx,
	input  wire [4:0] i_if_started,
	input  wire [4:0] i_if_event,
	input  wire       i_card_three_reset_bit,
	input  wire       i_aux_option,
	input  wire [2:0] i_interface_number_field,
	input  wire       i_card_one_io_drive,
	input  wire       i_card_one_c4_drive,
	input  wire       i_card_one_c8_drive,
	input  wire       i_card_io_pin_one,
	output wire       o_card_io_pin_one,
	output wire       o_card_io_pin_one_oe,
	input  wire       i_card_io_pin_two,
	output wire       o_card_io_pin_two,
	output wire       o_card_io_pin_two_oe,
	input  wire       i_shared_io3_c4_card_two_pin,
	output wire       o_shared_io3_c4_card_two_pin,
	output wire       o_shared_io3_c4_card_two_pin_oe,
	input  wire       i_card_io_pin_four,
	output wire       o_card_io_pin_four,
	output wire       o_card_io_pin_four_oe,
	input  wire       i_card_io_pin_five,
	output wire       o_card_io_pin_five,
	output wire       o_card_io_pin_five_oe,
	input  wire       i_card_one_c4_pin,
	output wire       o_card_one_c4_pin,
	output wire       o_card_one_c4_pin_oe,
	input  wire       i_card_one_c8_pin,
	output wire       o_card_one_c8_pin,
	output wire       o_card_one_c8_pin_oe,
	input  wire       i_shared_reset3_c8_card_two_pin,
	output wire       o_shared_reset3_c8_card_two_pin,
	output wire       o_shared_reset3_c8_card_two_pin_oe,
	input  wire       i_card_two_reset_pin,
	input  wire       i_card_two_present,
	output wire [1:0] o_converter_b_startup_current,
	output wire       o_irq_n
);

	////////////////////////////////////////////////////////////////////////////////
	// Functions
	// Line index (bit 2 = reached) of the host line whose target is the given pin
	function [2:0] cior_src;
		input [3:0]  pin;
		input [15:0] tgts;
		begin
			if (tgts[3:0] == pin)
				cior_src = 3'h4;
			else if (tgts[7:4] == pin)
				cior_src = 3'h5;
			else if (tgts[11:8] == pin)
				cior_src = 3'h6;
			else if (tgts[15:12] == pin)
				cior_src = 3'h7;
			else
				cior_src = 3'h0;
		end
	endfunction

	// Open-drain enable: a stopped interface holds low, static drive lets 1 float
	function cior_oe;
		input started;
		input static_sel;
		input host_lvl;
		input drv;
		begin
			if (!started)
				cior_oe = 1'b1;
			else if (static_sel)
				cior_oe = ~drv;
			else
				cior_oe = ~host_lvl;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	wire [13:0] sync_level;
	wire        host_l1;
	wire        host_l2;
	wire        host_a1;
	wire        host_a2;
	wire        lvl_io1;
	wire        lvl_io2;
	wire        lvl_sh3;
	wire        lvl_io4;
	wire        lvl_io5;
	wire        lvl_c41;
	wire        lvl_c81;
	wire        lvl_rst3;
	wire        lvl_rst2;
	wire        lvl_present;

	cior_sync #(.WIDTH(14)) u_sync
	(
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.i_async   ({i_card_two_present, i_card_two_reset_pin,
		             i_shared_reset3_c8_card_two_pin, i_card_one_c8_pin,
		             i_card_one_c4_pin, i_card_io_pin_five, i_card_io_pin_four,
		             i_shared_io3_c4_card_two_pin, i_card_io_pin_two, i_card_io_pin_one,
		             i_host_aux_two, i_host_aux_one, i_host_line_two, i_host_line_one}),
		.o_level   (sync_level)
	);

	assign {lvl_present, lvl_rst2, lvl_rst3, lvl_c81, lvl_c41, lvl_io5, lvl_io4, lvl_sh3,
	        lvl_io2, lvl_io1, host_a2, host_a1, host_l2, host_l1} = sync_level;

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	reg [3:0] route_selector_reg;
	reg [6:0] card_b_static_drive_reg;
	reg [7:0] isolation_and_irq_mask_reg;
	reg [7:0] rdata_reg;
	reg [7:0] rdata_next;
	wire [7:0] card_b_pin_levels;

	always @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			route_selector_reg         <= `CIOR_RST_ROUTE_SEL;
			card_b_static_drive_reg    <= `CIOR_RST_STATIC_DRIVE;
			isolation_and_irq_mask_reg <= `CIOR_RST_ISO_MASK;
		end
		else if (i_reg_wr)
		begin
			// The pin level index has no write path
			case (i_reg_addr)
				`CIOR_IDX_ROUTE_SEL:    route_selector_reg <= i_reg_wdata[3:0];
				`CIOR_IDX_STATIC_DRIVE: card_b_static_drive_reg <= i_reg_wdata[6:0];
				`CIOR_IDX_ISO_MASK:     isolation_and_irq_mask_reg <= i_reg_wdata;
				default:                route_selector_reg <= route_selector_reg;
			endcase
		end
	end

	assign card_b_pin_levels = {1'b0,
	                            lvl_present,
	                            lvl_io5, lvl_io4, lvl_rst3, lvl_sh3,
	                            lvl_rst2, lvl_io2};

	always @*
	begin
		case (i_reg_addr)
			`CIOR_IDX_ROUTE_SEL:    rdata_next = {4'h0, route_selector_reg};
			`CIOR_IDX_STATIC_DRIVE: rdata_next = {1'b0, card_b_static_drive_reg};
			`CIOR_IDX_PIN_LEVELS:   rdata_next = card_b_pin_levels;
			default:                rdata_next = isolation_and_irq_mask_reg;
		endcase
	end

	always @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end

	assign o_reg_rdata = rdata_reg;
	// Field decoded in the converter; the code passes straight through
	assign o_converter_b_startup_current =
		card_b_static_drive_reg[`CIOR_DRV_STARTUP_HI:`CIOR_DRV_STARTUP_LO];

	////////////////////////////////////////////////////////////////////////////////
	// Routing
	wire [3:0]  tgt_l1;
	wire [3:0]  tgt_l2;
	wire [3:0]  tgt_a1;
	wire [3:0]  tgt_a2;
	wire [15:0] tgts;
	wire [3:0]  host_vec;
	wire [8:0]  pin_vec;
	wire        rst3_code;
	wire [2:0]  src_io1;
	wire [2:0]  src_io2;
	wire [2:0]  src_sh3;
	wire [2:0]  src_io4;
	wire [2:0]  src_io5;
	wire [2:0]  src_c41;
	wire [2:0]  src_c81;
	wire [2:0]  src_rst3;
	wire        rst3_routed;
	wire        sh3_is_io3;
	wire        iso_two;
	wire        iso_sh3;

	cior_route u_route
	(
		.i_route_selector (route_selector_reg),
		.o_tgt_line_one   (tgt_l1),
		.o_tgt_line_two   (tgt_l2),
		.o_tgt_aux_one    (tgt_a1),
		.o_tgt_aux_two    (tgt_a2)
	);

	assign tgts     = {tgt_a2, tgt_a1, tgt_l2, tgt_l1};
	assign host_vec = {host_a2, host_a1, host_l2, host_l1};
	// Index 0 stands for no pin: an idle host line reads high
	assign pin_vec  = {lvl_rst3, lvl_c81, lvl_c41, lvl_io5, lvl_io4,
	                   lvl_sh3, lvl_io2, lvl_io1, 1'b1};

	assign src_io1  = cior_src(`CIOR_T_IO_ONE, tgts);
	assign src_io2  = cior_src(`CIOR_T_IO_TWO, tgts);
	assign src_sh3  = cior_src(`CIOR_T_SHARED3, tgts);
	assign src_io4  = cior_src(`CIOR_T_IO_FOUR, tgts);
	assign src_io5  = cior_src(`CIOR_T_IO_FIVE, tgts);
	assign src_c41  = cior_src(`CIOR_T_C4_ONE, tgts);
	assign src_c81  = cior_src(`CIOR_T_C8_ONE, tgts);
	assign src_rst3 = cior_src(`CIOR_T_SHARED_RST3, tgts);
	// Aux two reaches reset3 only while the card-three reset bit is set
	assign rst3_code   = (route_selector_reg == `CIOR_SEL_RST3_A) ||
	                     (route_selector_reg == `CIOR_SEL_RST3_B);
	assign rst3_routed = src_rst3[2] & rst3_code & i_card_three_reset_bit;

	// Shared pin serves I/O3 or C4 of card two
	assign sh3_is_io3 = ~i_aux_option | (i_interface_number_field == `CIOR_IFN_IO3);
	assign iso_two = isolation_and_irq_mask_reg[`CIOR_ISO_CARD_TWO];
	assign iso_sh3 = sh3_is_io3 ? isolation_and_irq_mask_reg[`CIOR_ISO_IO_THREE] :
	                 iso_two;

	////////////////////////////////////////////////////////////////////////////////
	// Pin drivers
	reg [7:0] oe_reg;
	reg [7:0] oe_next;
	reg [3:0] rx_reg;

	always @*
	begin
		oe_next[0] = cior_oe(i_if_started[0], ~src_io1[2],
		                     host_vec[src_io1[1:0]], i_card_one_io_drive);
		oe_next[1] = cior_oe(i_if_started[1], iso_two | ~src_io2[2],
		                     host_vec[src_io2[1:0]],
		                     card_b_static_drive_reg[`CIOR_DRV_IO_TWO]);
		oe_next[2] = cior_oe(sh3_is_io3 ? i_if_started[2] : i_if_started[1],
		                     iso_sh3 | ~src_sh3[2], host_vec[src_sh3[1:0]],
		                     card_b_static_drive_reg[`CIOR_DRV_SHARED3]);
		oe_next[3] = cior_oe(i_if_started[3],
		                     isolation_and_irq_mask_reg[`CIOR_ISO_IO_FOUR] | ~src_io4[2],
		                     host_vec[src_io4[1:0]],
		                     card_b_static_drive_reg[`CIOR_DRV_IO_FOUR]);
		oe_next[4] = cior_oe(i_if_started[4],
		                     isolation_and_irq_mask_reg[`CIOR_ISO_IO_FIVE] | ~src_io5[2],
		                     host_vec[src_io5[1:0]],
		                     card_b_static_drive_reg[`CIOR_DRV_IO_FIVE]);
		oe_next[5] = cior_oe(i_if_started[0], ~src_c41[2],
		                     host_vec[src_c41[1:0]], i_card_one_c4_drive);
		oe_next[6] = cior_oe(i_if_started[0], ~src_c81[2],
		                     host_vec[src_c81[1:0]], i_card_one_c8_drive);
		// Routed reset3 belongs to interface three, the C8 use to interface two
		oe_next[7] = cior_oe(rst3_routed ? i_if_started[2] : i_if_started[1],
		                     iso_two | ~rst3_routed, host_vec[src_rst3[1:0]],
		                     card_b_static_drive_reg[`CIOR_DRV_C8_CARD_TWO]);
	end

	// Pins after reset are held low until the interfaces start
	always @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			oe_reg <= 8'hFF;
			rx_reg <= 4'hF;
		end
		else
		begin
			oe_reg    <= oe_next;
			rx_reg[0] <= pin_vec[tgt_l1];
			rx_reg[1] <= pin_vec[tgt_l2];
			rx_reg[2] <= pin_vec[tgt_a1];
			rx_reg[3] <= (tgt_a2 == `CIOR_T_SHARED_RST3 && !rst3_routed) ? 1'b1 :
			             pin_vec[tgt_a2];
		end
	end

	// Open drain: a pin is only ever pulled low, a high comes from the pull-up
	assign {o_shared_reset3_c8_card_two_pin, o_card_one_c8_pin, o_card_one_c4_pin,
	        o_card_io_pin_five, o_card_io_pin_four, o_shared_io3_c4_card_two_pin,
	        o_card_io_pin_two, o_card_io_pin_one} = 8'h00;
	assign {o_shared_reset3_c8_card_two_pin_oe, o_card_one_c8_pin_oe, o_card_one_c4_pin_oe,
	        o_card_io_pin_five_oe, o_card_io_pin_four_oe, o_shared_io3_c4_card_two_pin_oe,
	        o_card_io_pin_two_oe, o_card_io_pin_one_oe} = oe_reg;
	assign {o_host_aux_two_rx, o_host_aux_one_rx,
	        o_host_line_two_rx, o_host_line_one_rx} = rx_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt
	reg irq_n_reg;
	// Flags live in the interfaces; masking only keeps them off the pin
	always @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
			irq_n_reg <= 1'b1;
		else
			irq_n_reg <= ~(i_if_event[0] |
			               (|(i_if_event[4:1] & ~isolation_and_irq_mask_reg[3:0])));
	end
	assign o_irq_n = irq_n_reg;

endmodule

// *** cior_defs.vh ***
// Register indices, field positions, reset values and routing codes of the card IO matrix
`ifndef CIOR_DEFS_VH
`define CIOR_DEFS_VH

// Register indices on the register port
`define CIOR_IDX_ROUTE_SEL      2'h0
`define CIOR_IDX_STATIC_DRIVE   2'h1
`define CIOR_IDX_PIN_LEVELS     2'h2
`define CIOR_IDX_ISO_MASK       2'h3

// Reset values
`define CIOR_RST_ROUTE_SEL      4'h8
`define CIOR_RST_STATIC_DRIVE   7'h00
`define CIOR_RST_ISO_MASK       8'h00

// Static drive register fields
`define CIOR_DRV_STARTUP_LO     0
`define CIOR_DRV_STARTUP_HI     1
`define CIOR_DRV_IO_TWO         2
`define CIOR_DRV_SHARED3        3
`define CIOR_DRV_IO_FOUR        4
`define CIOR_DRV_IO_FIVE        5
`define CIOR_DRV_C8_CARD_TWO    6

// Pin level register fields
`define CIOR_LVL_IO_TWO         0
`define CIOR_LVL_RESET_TWO      1
`define CIOR_LVL_SHARED3        2
`define CIOR_LVL_SHARED_RST3    3
`define CIOR_LVL_IO_FOUR        4
`define CIOR_LVL_IO_FIVE        5
`define CIOR_LVL_PRESENT_TWO    6

// Isolation and interrupt mask register fields
`define CIOR_MSK_IF_TWO         0
`define CIOR_MSK_IF_THREE       1
`define CIOR_MSK_IF_FOUR        2
`define CIOR_MSK_IF_FIVE        3
`define CIOR_ISO_CARD_TWO       4
`define CIOR_ISO_IO_THREE       5
`define CIOR_ISO_IO_FOUR        6
`define CIOR_ISO_IO_FIVE        7

// Startup current codes of converter B
`define CIOR_BOOST_NORMAL       2'h0
`define CIOR_BOOST_PLUS18       2'h1
`define CIOR_BOOST_PLUS18_OSC   2'h2
`define CIOR_BOOST_PLUS40       2'h3

// Card pin targets of one host line
`define CIOR_T_NONE             4'h0
`define CIOR_T_IO_ONE           4'h1
`define CIOR_T_IO_TWO           4'h2
`define CIOR_T_SHARED3          4'h3
`define CIOR_T_IO_FOUR          4'h4
`define CIOR_T_IO_FIVE          4'h5
`define CIOR_T_C4_ONE           4'h6
`define CIOR_T_C8_ONE           4'h7
`define CIOR_T_SHARED_RST3      4'h8

// Selector codes that reach the shared reset3 pin
`define CIOR_SEL_RST3_A         4'hE
`define CIOR_SEL_RST3_B         4'hF

// Interface number that keeps the shared pin on I/O3 with the aux option
`define CIOR_IFN_IO3            3'h2

`endif

// *** cior_sync.v ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module cior_sync
#(
	parameter WIDTH = 14
)
(
	input  wire             i_clk_sys,
	input  wire             i_sys_rst,
	input  wire [WIDTH-1:0] i_async,
	output wire [WIDTH-1:0] o_level
);

	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;
	reg [WIDTH-1:0] stage3_reg;
	reg [WIDTH-1:0] level_reg;
	integer         k;

	// Stage one feeds only stage two; a bit changes once stages two and three agree
	always @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
			stage3_reg <= {WIDTH{1'b0}};
			level_reg  <= {WIDTH{1'b0}};
		end
		else
		begin
			stage1_reg <= i_async;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			for (k = 0; k < WIDTH; k = k + 1)
			begin
				if (stage2_reg[k] == stage3_reg[k])
					level_reg[k] <= stage3_reg[k];
			end
		end
	end

	assign o_level = level_reg;

endmodule

// *** cior_route.v ***
// Selector table: card pin reached by each host line
`timescale 1ns/1ps
`include "cior_defs.vh"

module cior_route
(
	input  wire [3:0] i_route_selector,
	output reg  [3:0] o_tgt_line_one,
	output reg  [3:0] o_tgt_line_two,
	output reg  [3:0] o_tgt_aux_one,
	output reg  [3:0] o_tgt_aux_two
);

	always @*
	begin
		o_tgt_line_one = `CIOR_T_IO_ONE;
		o_tgt_line_two = `CIOR_T_NONE;
		o_tgt_aux_one  = `CIOR_T_NONE;
		o_tgt_aux_two  = `CIOR_T_NONE;
		case (i_route_selector)
			// Line one alone
			4'h0: o_tgt_line_one = `CIOR_T_IO_ONE;
			4'h1: o_tgt_line_one = `CIOR_T_IO_TWO;
			4'h2: o_tgt_line_one = `CIOR_T_SHARED3;
			4'h3: o_tgt_line_one = `CIOR_T_IO_FOUR;
			4'h4: o_tgt_line_one = `CIOR_T_IO_FIVE;
			// Line one on I/O one, aux one on C4 of card one
			4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB:
			begin
				o_tgt_aux_one = `CIOR_T_C4_ONE;
				case (i_route_selector)
					4'h5:    o_tgt_line_two = `CIOR_T_IO_TWO;
					4'h6:    o_tgt_line_two = `CIOR_T_IO_TWO;
					4'h7:    o_tgt_line_two = `CIOR_T_IO_TWO;
					4'h8:    o_tgt_line_two = `CIOR_T_IO_TWO;
					4'h9:    o_tgt_line_two = `CIOR_T_SHARED3;
					4'hA:    o_tgt_line_two = `CIOR_T_IO_FOUR;
					default: o_tgt_line_two = `CIOR_T_IO_FIVE;
				endcase
				case (i_route_selector)
					4'h5:    o_tgt_aux_two = `CIOR_T_SHARED3;
					4'h6:    o_tgt_aux_two = `CIOR_T_IO_FOUR;
					4'h7:    o_tgt_aux_two = `CIOR_T_IO_FIVE;
					default: o_tgt_aux_two = `CIOR_T_C8_ONE;
				endcase
			end
			// Aux one on the shared I/O3 / C4 pin
			4'hC:
			begin
				o_tgt_line_two = `CIOR_T_IO_FIVE;
				o_tgt_aux_one  = `CIOR_T_SHARED3;
				o_tgt_aux_two  = `CIOR_T_IO_FOUR;
			end
			4'hD:
			begin
				o_tgt_line_one = `CIOR_T_IO_TWO;
				o_tgt_line_two = `CIOR_T_IO_FIVE;
				o_tgt_aux_one  = `CIOR_T_SHARED3;
				o_tgt_aux_two  = `CIOR_T_IO_FOUR;
			end
			4'hE:
			begin
				o_tgt_line_one = `CIOR_T_IO_TWO;
				o_tgt_line_two = `CIOR_T_IO_FOUR;
				o_tgt_aux_one  = `CIOR_T_SHARED3;
				o_tgt_aux_two  = `CIOR_T_SHARED_RST3;
			end
			default:
			begin
				o_tgt_line_one = `CIOR_T_IO_TWO;
				o_tgt_line_two = `CIOR_T_IO_FIVE;
				o_tgt_aux_one  = `CIOR_T_SHARED3;
				o_tgt_aux_two  = `CIOR_T_SHARED_RST3;
			end
		endcase
	end

endmodule

// *** cior_monitor.sv ***
// Port checker of the card IO routing matrix
`timescale 1ns/1ps
module cior_monitor
(
	input wire       i_clk_sys,
	input wire       i_sys_rst,
	input wire       i_reg_wr,
	input wire [1:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	input wire [7:0] o_reg_rdata,
	input wire [4:0] i_if_started,
	input wire [4:0] i_if_event,
	input wire       i_card_three_reset_bit,
	input wire       i_aux_option,
	input wire [2:0] i_interface_number_field,
	input wire       o_card_io_pin_two_oe,
	input wire       o_shared_io3_c4_card_two_pin_oe,
	input wire       o_card_io_pin_four_oe,
	input wire       o_card_io_pin_five_oe,
	input wire       o_shared_reset3_c8_card_two_pin_oe,
	input wire [1:0] o_converter_b_startup_current,
	input wire       o_irq_n
);
reg  [3:0] sel_reg;
reg  [6:0] drv_reg;
reg  [7:0] iso_reg;
wire       irq_exp = i_if_event[0] | (|(i_if_event[4:1] & ~iso_reg[3:0]));
wire       rst3_rt = (sel_reg[3:1] == 3'h7) & i_card_three_reset_bit;
// Codes in which no host line reaches I/O two
wire       io2_free = ~((sel_reg == 4'h1) | (sel_reg >= 4'h5 & sel_reg <= 4'h8) | (sel_reg >= 4'hD));
wire       io3_mode = ~i_aux_option | (i_interface_number_field == 3'h2);

always @(posedge i_clk_sys)
begin
	if (i_sys_rst)
	begin
		sel_reg <= 4'h8;
		drv_reg <= 7'h00;
		iso_reg <= 8'h00;
	end
	else if (i_reg_wr)
	begin
		if (i_reg_addr == 2'h0)
			sel_reg <= i_reg_wdata[3:0];
		if (i_reg_addr == 2'h1)
			drv_reg <= i_reg_wdata[6:0];
		if (i_reg_addr == 2'h3)
			iso_reg <= i_reg_wdata;
	end
end

////////////////////////////////////////////////////////////////
default clocking cb @(posedge i_clk_sys); endclocking
default disable iff (i_sys_rst);

a_reset_pins_low: assert property (disable iff (1'b0) i_sys_rst |=>
	o_card_io_pin_two_oe && o_card_io_pin_five_oe && o_irq_n && o_converter_b_startup_current == 2'h0)
	else $error("reset state of pins wrong");
a_irq_unmasked: assert property (1 |=> o_irq_n == ~$past(irq_exp))
	else $error("interrupt level wrong");
a_startup_code: assert property (i_reg_wr && i_reg_addr == 2'h1 |=> ##1
	o_converter_b_startup_current == $past(i_reg_wdata[1:0], 2)) else $error("startup code wrong");
a_sel_readback: assert property (i_reg_addr == 2'h0 |=> o_reg_rdata == {4'h0, $past(sel_reg)})
	else $error("selector read wrong");
a_drv_readback: assert property (i_reg_addr == 2'h1 |=> o_reg_rdata == {1'b0, $past(drv_reg)})
	else $error("drive read wrong");
a_level_top_zero: assert property (i_reg_addr == 2'h2 |=> o_reg_rdata[7] == 1'b0)
	else $error("level bit 7 set");
a_io4_isolated: assert property (i_if_started[3] && iso_reg[6] |=>
	o_card_io_pin_four_oe == ~$past(drv_reg[4])) else $error("isolated io4 wrong");
a_io5_stopped: assert property (!i_if_started[4] |=> o_card_io_pin_five_oe)
	else $error("stopped io5 not low");
a_io2_static: assert property (i_if_started[1] && (iso_reg[4] || io2_free) |=>
	o_card_io_pin_two_oe == ~$past(drv_reg[2])) else $error("static io2 wrong");
a_rst3_static: assert property (i_if_started[1] && !rst3_rt |=>
	o_shared_reset3_c8_card_two_pin_oe == ~$past(drv_reg[6])) else $error("static reset3 wrong");
a_io3_isolated: assert property (i_if_started[2] && io3_mode && iso_reg[5] |=>
	o_shared_io3_c4_card_two_pin_oe == ~$past(drv_reg[3])) else $error("isolated io3 wrong");

c_irq_low: cover property (!o_irq_n);
c_rst3_routed: cover property (rst3_rt && i_if_started[2]);
c_io4_iso: cover property (i_if_started[3] && iso_reg[6]);
endmodule

bind cior_top cior_monitor u_mon (.i_clk_sys, .i_sys_rst, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
	.o_reg_rdata, .i_if_started, .i_if_event, .i_card_three_reset_bit, .i_aux_option,
	.i_interface_number_field, .o_card_io_pin_two_oe, .o_shared_io3_c4_card_two_pin_oe,
	.o_card_io_pin_four_oe, .o_card_io_pin_five_oe, .o_shared_reset3_c8_card_two_pin_oe,
	.o_converter_b_startup_current, .o_irq_n);

// *** cior_card_model.sv ***
// Card side of the open-drain card pins
`timescale 1ns/1ps
module cior_card_model
(
	input  wire [7:0] i_oe,
	input  wire [7:0] i_pull_low,
	output wire [7:0] o_level
);
// A released pin reads high through the pull-up unless the card holds it low
assign o_level = ~(i_oe | i_pull_low);
endmodule

// *** testbench.sv ***
// Directed register and pin tests of the card IO routing matrix
`timescale 1ns/1ps
module testbench;
logic       i_clk_sys = 1'b0;
logic       i_sys_rst = 1'b1;
logic       i_reg_wr = 1'b0;
logic [1:0] i_reg_addr = 2'h0;
logic [7:0] i_reg_wdata = 8'h00;
logic [4:0] i_if_started = 5'h00;
logic [4:0] i_if_event = 5'h00;
logic [2:0] i_interface_number_field = 3'h2;
logic [7:0] pull = 8'h00;
logic       i_aux_option = 1'b0;
logic       i_host_line_one = 1'b0;
logic       i_host_aux_two = 1'b0;
logic       i_host_line_two = 1'b1;
logic       i_host_aux_one = 1'b1;
logic       i_card_three_reset_bit = 1'b1;
logic       i_card_two_reset_pin = 1'b1;
logic       i_card_two_present = 1'b1;
logic       i_card_one_io_drive = 1'b0;
logic       i_card_one_c4_drive = 1'b0;
logic       i_card_one_c8_drive = 1'b0;
int         num_errors = 0;
int         check_count = 0;
wire  [7:0] o_reg_rdata;
wire  [7:0] oe;
wire  [7:0] lvl;
wire  [3:0] rx;
wire  [1:0] o_converter_b_startup_current;
wire        o_irq_n;

always #2 i_clk_sys = ~i_clk_sys;

cior_top dut (.*,
	.o_host_line_one_rx(rx[0]), .o_host_line_two_rx(rx[1]),
	.o_host_aux_one_rx(rx[2]), .o_host_aux_two_rx(rx[3]),
	.i_card_io_pin_one(lvl[0]), .o_card_io_pin_one(), .o_card_io_pin_one_oe(oe[0]),
	.i_card_io_pin_two(lvl[1]), .o_card_io_pin_two(), .o_card_io_pin_two_oe(oe[1]),
	.i_shared_io3_c4_card_two_pin(lvl[2]), .o_shared_io3_c4_card_two_pin(),
	.o_shared_io3_c4_card_two_pin_oe(oe[2]),
	.i_card_io_pin_four(lvl[3]), .o_card_io_pin_four(), .o_card_io_pin_four_oe(oe[3]),
	.i_card_io_pin_five(lvl[4]), .o_card_io_pin_five(), .o_card_io_pin_five_oe(oe[4]),
	.i_card_one_c4_pin(lvl[5]), .o_card_one_c4_pin(), .o_card_one_c4_pin_oe(oe[5]),
	.i_card_one_c8_pin(lvl[6]), .o_card_one_c8_pin(), .o_card_one_c8_pin_oe(oe[6]),
	.i_shared_reset3_c8_card_two_pin(lvl[7]), .o_shared_reset3_c8_card_two_pin(),
	.o_shared_reset3_c8_card_two_pin_oe(oe[7]));

cior_card_model card (.i_oe(oe), .i_pull_low(pull), .o_level(lvl));

////////////////////////////////////////////////////////////////
// Pin level bits pulled low by host line one and by aux two in each code
function automatic [7:0] low_mask(input [3:0] s);
	case (s)
		4'h1, 4'hD: low_mask = 8'h01 | ((s == 4'hD) ? 8'h10 : 8'h00);
		4'h2, 4'h5: low_mask = 8'h04;
		4'h3, 4'h6, 4'hC: low_mask = 8'h10;
		4'h4, 4'h7: low_mask = 8'h20;
		4'hE, 4'hF: low_mask = 8'h09;
		default: low_mask = 8'h00;
	endcase
endfunction

task automatic chk(input string n, input [7:0] e, input [7:0] g);
	begin
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	end
endtask

task automatic wr(input [1:0] a, input [7:0] d);
	begin
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	end
endtask

// Waits out the pin synchronisers before every read
task automatic rd(input [1:0] a, input [7:0] e, input string n);
	begin
		repeat (8) @(posedge i_clk_sys);
		i_reg_addr <= a;
		@(posedge i_clk_sys);
		#1 chk(n, e, o_reg_rdata);
	end
endtask

task automatic irq(input e);
	begin
		repeat (3) @(posedge i_clk_sys);
		#1 chk("irq_n", {7'h00, e}, {7'h00, o_irq_n});
	end
endtask

task automatic close_out;
	begin
		if (num_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
endtask

////////////////////////////////////////////////////////////////
initial
begin
	repeat (4) @(posedge i_clk_sys);
	i_sys_rst <= 1'b0;
	rd(2'h0, 8'h08, "selector");
	rd(2'h1, 8'h00, "drive");
	rd(2'h3, 8'h00, "iso_mask");
	wr(2'h2, 8'hFF);
	rd(2'h2, 8'h42, "levels");
	for (int c = 0; c < 4; c++)
	begin
		wr(2'h1, 8'hFC | c[7:0]);
		rd(2'h1, 8'h7C | c[7:0], "drive");
		chk("startup", c[7:0], {6'h00, o_converter_b_startup_current});
	end
	i_if_started <= 5'h1F;
	wr(2'h3, 8'hF0);
	rd(2'h2, 8'h7F, "levels");
	pull <= 8'h08;
	rd(2'h2, 8'h6F, "levels");
	pull <= 8'h00;
	i_card_two_present <= 1'b0;
	wr(2'h1, 8'h00);
	rd(2'h2, 8'h02, "levels");
	i_card_two_present <= 1'b1;
	wr(2'h1, 8'h7C);
	wr(2'h0, 8'h05);
	wr(2'h3, 8'hE0);
	rd(2'h2, 8'h7F, "levels");
	i_aux_option <= 1'b1;
	i_interface_number_field <= 3'h3;
	rd(2'h2, 8'h7B, "levels");
	i_aux_option <= 1'b0;
	i_interface_number_field <= 3'h2;
	wr(2'h3, 8'h00);
	for (int s = 0; s < 16; s++)
	begin
		wr(2'h0, s[7:0]);
		rd(2'h2, 8'h7F & ~low_mask(s[3:0]), "levels");
	end
	i_card_three_reset_bit <= 1'b0;
	rd(2'h2, 8'h7E, "levels");
	chk("pin_oe", 8'h63, oe);
	chk("host_rx", 8'h0E, {4'h0, rx});
	for (int i = 1; i < 5; i++)
	begin
		i_if_event <= 5'h01 << i;
		wr(2'h3, 8'h01 << (i - 1));
		irq(1'b1);
		wr(2'h3, 8'h00);
		irq(1'b0);
	end
	i_if_event <= 5'h01;
	wr(2'h3, 8'h0F);
	irq(1'b0);
	close_out;
end

initial
begin
	repeat (5000) @(posedge i_clk_sys);
	num_errors++;
	close_out;
end
endmodule
